// ==== verilog/tfskip_pkg.sv ====
// Purpose: constants for the timer request flag skip instruction unit
// Assumes: one 50 MHz core clock, asynchronous active-low reset
// Notes:   flags are held in tfskip_flag; timers raise them by one-cycle set pulses
//
// Behaviour
// - timer-1 enable 0 and flag set: clear flag, skip next instruction.
// - timer-1 enable 0 and flag clear: next instruction runs normally.
// - timer-1 enable 1: instruction is a no-op, flag untouched, no skip.
// - timer-2 instruction is one word, one cycle, carry unchanged.
// - timer-2 enable 0 and flag set: clear flag, skip next instruction.
// - timer-2 skip decided only while its enable is 0, flag set.
// - timer-2 enable 0 and flag clear: next instruction runs normally.
package tfskip_pkg;
  localparam logic FLAG_RESET  = 1'h0;
  localparam logic SKIP_RESET  = 1'h0;
  localparam logic DONE_RESET  = 1'h0;
  localparam logic CARRY_RESET = 1'h0;
  localparam int   EXEC_CYCLES = 1;
  localparam int   NUM_TIMERS  = 2;
endpackage

// ==== verilog/tfskip_flag.sv ====
// Purpose: one timer request flag with skip test
// Assumes: set pulse from the timer, test strobe from the sequencer
// Notes:   a set arriving with the clearing test wins, so no request is lost
module tfskip_flag
  import tfskip_pkg::*;
(
  input  wire logic i_clk,
  input  wire logic i_nrst,
  input  wire logic i_set,
  input  wire logic i_test,
  input  wire logic i_irq_enable_bit,
  output logic      o_flag,
  output logic      o_skip_hit
);
  logic armed;
  assign armed      = i_test && !i_irq_enable_bit;
  assign o_skip_hit = armed && o_flag;

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_flag <= FLAG_RESET;
    end else if (i_set) begin
      o_flag <= 1'h1;
    end else if (o_skip_hit) begin
      o_flag <= 1'h0;
    end
  end
endmodule // tfskip_flag

// ==== verilog/tfskip_unit.sv ====
// Purpose: execution of the two timer request skip instructions
// Assumes: sequencer strobes at most one instruction per cycle
// Notes:   o_skip_next is registered; sequencer drops the following word when high
module tfskip_unit
  import tfskip_pkg::*;
#(
  parameter int N_TIMERS = NUM_TIMERS
) (
  input  wire logic i_clk,
  input  wire logic i_nrst,
  input  wire logic i_skip_on_timer1_request,
  input  wire logic i_skip_on_timer2_request,
  input  wire logic i_timer1_irq_enable_bit,
  input  wire logic i_timer2_irq_enable_bit,
  input  wire logic i_timer1_set,
  input  wire logic i_timer2_set,
  input  wire logic i_carry_flag,
  output logic      o_timer1_request_flag,
  output logic      o_timer2_request_flag,
  output logic      o_skip_next,
  output logic      o_carry_flag,
  output logic      o_done
);
  // ----------------------------------------------------------------
  // parameter checks
  // ----------------------------------------------------------------
  // the ports name two timers; any other count has nowhere to go
  if (N_TIMERS != 2) begin : g_bad_timers
    $error("tfskip_unit serves exactly two timers");
  end
  if (EXEC_CYCLES != 1) begin : g_bad_cycles
    $error("tfskip_unit answers exactly one cycle after the strobe");
  end

  // ----------------------------------------------------------------
  // per-timer packing
  // ----------------------------------------------------------------
  logic [N_TIMERS-1:0] set_vec;
  logic [N_TIMERS-1:0] test_vec;
  logic [N_TIMERS-1:0] enable_vec;
  logic [N_TIMERS-1:0] flag_vec;
  logic [N_TIMERS-1:0] hit_vec;
  logic                hit1;
  logic                hit2;

  assign set_vec    = {i_timer2_set, i_timer1_set};
  assign test_vec   = {i_skip_on_timer2_request, i_skip_on_timer1_request};
  assign enable_vec = {i_timer2_irq_enable_bit, i_timer1_irq_enable_bit};
  assign hit1       = hit_vec[0];
  assign hit2       = hit_vec[1];

  // ----------------------------------------------------------------
  // request flags
  // ----------------------------------------------------------------
  // a set pulse meeting a clearing test wins, so no request is lost
  for (genvar gi = 0; gi < N_TIMERS; gi++) begin : g_timer
    tfskip_flag tfskip_flag_i (
      .i_clk            (i_clk),
      .i_nrst           (i_nrst),
      .i_set            (set_vec[gi]),
      .i_test           (test_vec[gi]),
      .i_irq_enable_bit (enable_vec[gi]),
      .o_flag           (flag_vec[gi]),
      .o_skip_hit       (hit_vec[gi])
    );
  end

  // each flag leaves straight from the flop inside its cell
  assign o_timer1_request_flag = flag_vec[0];
  assign o_timer2_request_flag = flag_vec[1];

  // ----------------------------------------------------------------
  // skip decision
  // ----------------------------------------------------------------
  // registered: the sequencer drops the word it fetches next
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_skip_next <= SKIP_RESET;
    end else begin
      o_skip_next <= hit1 || hit2;
    end
  end

  // ----------------------------------------------------------------
  // completion
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_done <= DONE_RESET;
    end else begin
      o_done <= i_skip_on_timer1_request || i_skip_on_timer2_request;
    end
  end

  // ----------------------------------------------------------------
  // carry
  // ----------------------------------------------------------------
  // carry passes through untouched; a skip never writes it
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_carry_flag <= CARRY_RESET;
    end else begin
      o_carry_flag <= i_carry_flag;
    end
  end

  // ----------------------------------------------------------------
  // assertion setup
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_nrst);

  // ----------------------------------------------------------------
  // timer 1 assertions
  // ----------------------------------------------------------------
  a_t1_skip_clear: assert property (
    i_skip_on_timer1_request && !i_timer1_irq_enable_bit && o_timer1_request_flag
    && !i_timer1_set |=> o_skip_next && !o_timer1_request_flag)
    else $error("timer1 skip did not clear and skip");

  a_t1_set_beats_clear: assert property (
    i_skip_on_timer1_request && !i_timer1_irq_enable_bit && o_timer1_request_flag
    && i_timer1_set |=> o_skip_next && o_timer1_request_flag)
    else $error("timer1 set pulse lost under a clearing skip");

  a_t1_no_skip: assert property (
    i_skip_on_timer1_request && !i_timer1_irq_enable_bit && !o_timer1_request_flag
    && !i_skip_on_timer2_request |=> !o_skip_next)
    else $error("timer1 skipped with clear flag");

  a_t1_nop: assert property (
    i_skip_on_timer1_request && i_timer1_irq_enable_bit && !i_skip_on_timer2_request
    |=> !o_skip_next
    && o_timer1_request_flag == ($past(o_timer1_request_flag) || $past(i_timer1_set)))
    else $error("timer1 nop altered state");

  a_t1_set_wins: assert property (
    i_timer1_set |=> o_timer1_request_flag)
    else $error("timer1 set pulse did not raise the flag");

  a_t1_flag_hold: assert property (
    !i_timer1_set && !(i_skip_on_timer1_request && !i_timer1_irq_enable_bit)
    |=> $stable(o_timer1_request_flag))
    else $error("timer1 flag changed without set or test");

  a_t1_fall_by_test: assert property (
    $fell(o_timer1_request_flag) |-> $past(i_skip_on_timer1_request)
    && !$past(i_timer1_irq_enable_bit) && !$past(i_timer1_set))
    else $error("timer1 flag cleared without a taken skip");

  a_t1_enable_gate: assert property (
    o_skip_next && !$past(i_skip_on_timer2_request) |-> $past(i_skip_on_timer1_request)
    && !$past(i_timer1_irq_enable_bit) && $past(o_timer1_request_flag))
    else $error("timer1 skip without cause");

  a_t1_carry_kept: assert property (
    i_skip_on_timer1_request |=> o_done && o_carry_flag == $past(i_carry_flag))
    else $error("timer1 not single cycle or carry changed");

  // ----------------------------------------------------------------
  // timer 2 assertions
  // ----------------------------------------------------------------
  a_t2_one_cycle: assert property (
    i_skip_on_timer2_request |=> o_done && o_carry_flag == $past(i_carry_flag))
    else $error("timer2 not single cycle or carry changed");

  a_t2_skip_clear: assert property (
    i_skip_on_timer2_request && !i_timer2_irq_enable_bit && o_timer2_request_flag
    && !i_timer2_set |=> o_skip_next && !o_timer2_request_flag)
    else $error("timer2 skip did not clear and skip");

  a_t2_set_beats_clear: assert property (
    i_skip_on_timer2_request && !i_timer2_irq_enable_bit && o_timer2_request_flag
    && i_timer2_set |=> o_skip_next && o_timer2_request_flag)
    else $error("timer2 set pulse lost under a clearing skip");

  a_t2_enable_gate: assert property (
    o_skip_next && !$past(i_skip_on_timer1_request) |-> $past(i_skip_on_timer2_request)
    && !$past(i_timer2_irq_enable_bit) && $past(o_timer2_request_flag))
    else $error("timer2 skip without cause");

  a_t2_no_skip: assert property (
    i_skip_on_timer2_request && !i_timer2_irq_enable_bit && !o_timer2_request_flag
    && !i_skip_on_timer1_request |=> !o_skip_next)
    else $error("timer2 skipped with clear flag");

  a_t2_nop: assert property (
    i_skip_on_timer2_request && i_timer2_irq_enable_bit && !i_skip_on_timer1_request
    |=> !o_skip_next
    && o_timer2_request_flag == ($past(o_timer2_request_flag) || $past(i_timer2_set)))
    else $error("timer2 nop altered state");

  a_t2_set_wins: assert property (
    i_timer2_set |=> o_timer2_request_flag)
    else $error("timer2 set pulse did not raise the flag");

  a_t2_flag_hold: assert property (
    !i_timer2_set && !(i_skip_on_timer2_request && !i_timer2_irq_enable_bit)
    |=> $stable(o_timer2_request_flag))
    else $error("timer2 flag changed without set or test");

  a_t2_fall_by_test: assert property (
    $fell(o_timer2_request_flag) |-> $past(i_skip_on_timer2_request)
    && !$past(i_timer2_irq_enable_bit) && !$past(i_timer2_set))
    else $error("timer2 flag cleared without a taken skip");

  // ----------------------------------------------------------------
  // shared assertions
  // ----------------------------------------------------------------
  a_skip_has_done: assert property (
    o_skip_next |-> o_done)
    else $error("skip raised without a completed instruction");

  a_done_cause: assert property (
    o_done |-> $past(i_skip_on_timer1_request) || $past(i_skip_on_timer2_request))
    else $error("done raised without a strobe");

  // ----------------------------------------------------------------
  // cover points
  // ----------------------------------------------------------------
  c_t1_skip: cover property (i_skip_on_timer1_request && hit1);
  c_t2_skip: cover property (i_skip_on_timer2_request && hit2);
  c_t1_nop:  cover property (i_skip_on_timer1_request && i_timer1_irq_enable_bit);
  c_t2_nop:  cover property (i_skip_on_timer2_request && i_timer2_irq_enable_bit);
  c_set_win: cover property (hit1 && i_timer1_set);
endmodule // tfskip_unit

// ==== tb/tfskip_seq_model.sv ====
// Purpose: sequencer stand-in issuing skip instruction strobes
// Assumes: op changes on falling edges only
// Notes:   the word after a taken skip never reaches the unit
module tfskip_seq_model (
  input  wire logic       i_skip_next,
  input  wire logic [1:0] i_op,
  output logic            o_strobe1,
  output logic            o_strobe2
);
  timeunit 1ns;
  timeprecision 1ns;
  // dropped word, as a real fetch would discard it
  assign o_strobe1 = i_op[0] & ~i_skip_next;
  assign o_strobe2 = i_op[1] & ~i_skip_next;
endmodule // tfskip_seq_model

// ==== tb/timer_flag_skip_instructions_test.sv ====
// Purpose: random self-checking bench for the timer skip unit
// Assumes: inputs change on falling edges
// Notes:   expectations come from a flag model kept here
module timer_flag_skip_instructions_test;
  import tfskip_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic       clk, nrst, en1, en2, set1, set2, cy, s1, s2, f1, f2, sk, cyo, done;
  logic       m1, m2, pend, k;
  logic [1:0] op, eo;
  logic [3:0] q[$];
  logic [3:0] e;
  int         n_errors, check_count;

  tfskip_unit tfskip_unit_i (.i_clk(clk), .i_nrst(nrst),
    .i_skip_on_timer1_request(s1), .i_skip_on_timer2_request(s2),
    .i_timer1_irq_enable_bit(en1), .i_timer2_irq_enable_bit(en2),
    .i_timer1_set(set1), .i_timer2_set(set2), .i_carry_flag(cy),
    .o_timer1_request_flag(f1), .o_timer2_request_flag(f2),
    .o_skip_next(sk), .o_carry_flag(cyo), .o_done(done));
  tfskip_seq_model tfskip_seq_model_i (.i_skip_next(sk), .i_op(op),
    .o_strobe1(s1), .o_strobe2(s2));

  initial begin
    clk = 1'h0;
    forever #10 clk = ~clk;
  end

  task automatic check(string nm, logic seen, logic exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %b seen %b", nm, exp, seen);
    end
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // one cycle of stimulus; the flag model keeps the set-wins choice
  task automatic step(logic [1:0] o, logic [4:0] r);
    @(negedge clk);
    {en1, en2, set1, set2, cy} = r;
    op = o;
    // the word after a taken skip never reaches the unit
    eo = pend ? 2'h0 : op;
    k = eo[0] & ~en1 & m1 | eo[1] & ~en2 & m2;
    m1 = set1 | m1 & ~(eo[0] & ~en1);
    m2 = set2 | m2 & ~(eo[1] & ~en2);
    if (eo != 2'h0) q.push_back({k, m1, m2, cy});
    pend = k;
  endtask

  // results appear one cycle after the strobe edge
  always @(negedge clk) if (nrst === 1'h1) begin
    if (done === 1'h1 && q.size() > 0) begin
      e = q.pop_front();
      check("skip", sk, e[3]);
      check("flag1", f1, e[2]);
      check("flag2", f2, e[1]);
      check("carry", cyo, e[0]);
    end else begin
      check("done", done, 1'h0);
      check("idle skip", sk, 1'h0);
    end
  end

  initial begin
    {nrst, en1, en2, set1, set2, cy, op} = '0;
    {m1, m2, pend} = '0;
    void'($urandom(32'hcc37));
    repeat (3) @(negedge clk);
    nrst = 1'h1;
    for (int t = 0; t < 400; t++) begin
      step(2'($urandom % 3), 5'($urandom));
    end
    repeat (3) step(2'h0, 5'h00);
    check("drained", q.size() == 0, 1'h1);
    $display("random skip test done");
    // both flags and the carry up, then a reset in mid-run
    step(2'h0, 5'h07);
    step(2'h0, 5'h00);
    check("set flag1", f1, 1'h1);
    check("set flag2", f2, 1'h1);
    nrst = 1'h0;
    {m1, m2, pend} = '0;
    @(negedge clk);
    check("reset flag1", f1, 1'h0);
    check("reset flag2", f2, 1'h0);
    check("reset skip", sk, 1'h0);
    check("reset done", done, 1'h0);
    check("reset carry", cyo, 1'h0);
    nrst = 1'h1;
    // taken skip, dropped word, no-op under a set, then timer-2 skip
    step(2'h0, 5'h04);
    step(2'h1, 5'h01);
    step(2'h1, 5'h00);
    step(2'h2, 5'h0a);
    step(2'h2, 5'h00);
    repeat (3) step(2'h0, 5'h00);
    check("drained", q.size() == 0, 1'h1);
    $display("reset and directed skip test done");
    summarize();
  end

  // tests take about 420 cycles; allow well over twice that
  initial begin
    #20000;
    n_errors++;
    summarize();
  end
endmodule // timer_flag_skip_instructions_test
